//--- src/exp_bus_pkg.sv
// package: constants and carriers for the expansion bus controller
package exp_bus_pkg;
  localparam int NUM_CS      = 8;
  localparam int ADDR_W      = 24;
  localparam int DATA_W      = 16;
  localparam int PHASE_W     = 4;
  localparam int HPI_CS_LO   = 4;
  localparam int MIN_WIN_LOG = 9;
  localparam int MAX_WIN_LOG = 24;
  // clock rate and ceiling of the expansion clock
  localparam int CLK_MHZ_X100     = 20000;
  localparam int EXP_MAX_MHZ_X100 = 6666;
  localparam int CLK_PERIOD_PS    = 100000000 / CLK_MHZ_X100;
  localparam int EXP_MIN_PERIOD_PS = 100000000 / EXP_MAX_MHZ_X100;
  localparam int EXP_DIV_CYCLES   = (EXP_MIN_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // cycle styles
  localparam logic STYLE_RDWR  = 1'b0;
  localparam logic STYLE_RWSTB = 1'b1;
  localparam logic [7:0] CS_N_IDLE = 8'hff;

  typedef enum logic [1:0] {
    CYC_PLAIN, CYC_HPI8, CYC_HPI16
  } cyc_kind_t;

  // per chip select configuration
  typedef struct packed {
    logic              enable;
    logic              style;
    logic              muxed;
    cyc_kind_t         kind;
    logic [4:0]        win_log;
    logic [ADDR_W-1:0] base;
    logic [PHASE_W-1:0] t_addr;
    logic [PHASE_W-1:0] t_setup;
    logic [PHASE_W-1:0] t_strobe;
    logic [PHASE_W-1:0] t_hold;
    logic [PHASE_W-1:0] t_recov;
  } cs_cfg_t;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic              done;
    logic              miss;
    logic [DATA_W-1:0] rdata;
  } rsp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              addr_oe_n;
    logic [DATA_W-1:0] data;
    logic              data_oe_n;
    logic [NUM_CS-1:0] cs_n;
    logic              ale;
    logic              rd_n;
    logic              wr_n;
  } pins_t;
endpackage : exp_bus_pkg

//--- src/exp_bus_ctrl.sv
// expansion bus controller: five-phase strobed cycles on eight chip selects
// Function
// - 16-bit data, 24 address lines, eight selects, windows 512 B to 16 MB
// - each access runs five phases, twice for 8-bit host port cycles; lengths set per chip select
// - two strobe conventions selectable: rd/wr strobes or rw plus data strobe
// - per select, address and data either multiplexed or separate
// - selects 4 to 7 may run 8-bit or 16-bit dsp host port cycles
// - all phases paced from own clock; no peripheral clock sampled
// - address bus levels latched as straps at reset release
`timescale 1ns/1ps
`default_nettype none
module exp_bus_ctrl
  import exp_bus_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rstn_i,
  // configuration
  input  wire exp_bus_pkg::cs_cfg_t    cs_cfg_i [exp_bus_pkg::NUM_CS],
  // request and answer
  input  wire exp_bus_pkg::req_t       req_i,
  output var  exp_bus_pkg::rsp_t       rsp_o,
  output logic                         busy_o,
  output logic [exp_bus_pkg::ADDR_W-1:0] strap_o,
  // bus pins
  input  wire logic [exp_bus_pkg::ADDR_W-1:0] addr_pin_i,
  input  wire logic [exp_bus_pkg::DATA_W-1:0] data_pin_i,
  output var  exp_bus_pkg::pins_t      pins_o
);
  import exp_bus_pkg::*;

  // refuse a clock ratio the phase counters cannot serve
  if (EXP_DIV_CYCLES < 1) begin : g_bad_ratio
    $error("bad clock ratio");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SETUP, ST_STROBE, ST_HOLD, ST_RECOV
  } phase_t;

  typedef struct packed {
    phase_t             phase;
    logic               busy;
    logic [PHASE_W-1:0] cnt;
    logic [2:0]         cs;
    logic               write;
    logic               half;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic               strapped;
    logic [1:0]         rst_seen;
    logic [ADDR_W-1:0]  strap;
    logic [ADDR_W-1:0]  a_s1;
    logic [ADDR_W-1:0]  a_s2;
    logic [DATA_W-1:0]  d_s1;
    logic [DATA_W-1:0]  d_s2;
    rsp_t               rsp;
    pins_t              pins;
  } state_t;

  state_t st;
  state_t next_st;
  logic [NUM_CS-1:0] hit;
  logic [2:0]        hit_idx;
  logic              hit_any;

  genvar g;
  generate
    for (g = 0; g < NUM_CS; g++) begin : g_dec
      logic [ADDR_W-1:0] mask;
      assign mask = (cs_cfg_i[g].win_log < 5'(MIN_WIN_LOG)) ? ~((ADDR_W)'(1 << MIN_WIN_LOG) - 1'b1)
                  : ~(ADDR_W'(1 << cs_cfg_i[g].win_log) - 1'b1);
      assign hit[g] = cs_cfg_i[g].enable
                    && ((req_i.addr & mask) == (cs_cfg_i[g].base & mask));
    end
  endgenerate

  // lowest hit wins, only one select
  always_comb begin
    hit_idx = 3'h0;
    hit_any = 1'b0;
    for (int i = NUM_CS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_idx = 3'(i);
        hit_any = 1'b1;
      end
    end
  end

  function automatic logic [PHASE_W-1:0] len_of(input cs_cfg_t c, input phase_t p);
    unique case (p)
      ST_ADDR:   len_of = c.t_addr;
      ST_SETUP:  len_of = c.t_setup;
      ST_STROBE: len_of = c.t_strobe;
      ST_HOLD:   len_of = c.t_hold;
      default:   len_of = c.t_recov;
    endcase
  endfunction

  always_comb begin
    cs_cfg_t c;
    logic    hpi;
    logic    strb;
    c       = cs_cfg_i[st.cs];
    next_st = st;
    hpi     = (st.cs >= 3'(HPI_CS_LO)) && (c.kind != CYC_PLAIN);
    strb    = 1'b0;
    // pins sampled through two flops of own clock
    next_st.a_s1 = addr_pin_i;
    next_st.a_s2 = st.a_s1;
    next_st.d_s1 = data_pin_i;
    next_st.d_s2 = st.d_s1;
    next_st.rst_seen = {st.rst_seen[0], 1'b1};
    if (!st.strapped && st.rst_seen[1]) begin
      next_st.strap    = st.a_s2;
      next_st.strapped = 1'b1;
    end
    next_st.rsp.done = 1'b0;
    next_st.rsp.miss = 1'b0;
    unique case (st.phase)
      ST_IDLE: begin
        if (req_i.valid && st.strapped) begin
          if (!hit_any) begin
            next_st.rsp.miss = 1'b1;
            next_st.rsp.done = 1'b1;
          end else begin
            next_st.cs    = hit_idx;
            next_st.write = req_i.write;
            next_st.addr  = req_i.addr;
            next_st.wdata = req_i.wdata;
            next_st.half  = 1'b0;
            next_st.phase = ST_ADDR;
            next_st.cnt   = cs_cfg_i[hit_idx].t_addr;
          end
        end
      end
      default: begin
        if (st.cnt != '0) begin
          next_st.cnt = st.cnt - 1'b1;
        end else begin
          unique case (st.phase)
            ST_ADDR:   next_st.phase = ST_SETUP;
            ST_SETUP:  next_st.phase = ST_STROBE;
            ST_STROBE: next_st.phase = ST_HOLD;
            ST_HOLD:   next_st.phase = ST_RECOV;
            default:   next_st.phase = ST_IDLE;
          endcase
          next_st.cnt = len_of(c, next_st.phase);
          if (st.phase == ST_STROBE && !st.write) begin
            // 8-bit host port assembles two bytes, high first
            if (hpi && c.kind == CYC_HPI8)
              next_st.rdata = st.half ? {st.rdata[15:8], st.d_s2[7:0]}
                                      : {st.d_s2[7:0], 8'h00};
            else
              next_st.rdata = st.d_s2;
          end
          if (st.phase == ST_RECOV) begin
            if (hpi && c.kind == CYC_HPI8 && !st.half) begin
              next_st.half  = 1'b1;
              next_st.phase = ST_ADDR;
              next_st.cnt   = c.t_addr;
            end else begin
              next_st.rsp.done  = 1'b1;
              next_st.rsp.rdata = next_st.rdata;
            end
          end
        end
      end
    endcase
    // pin drive
    strb = (next_st.phase == ST_STROBE);
    next_st.pins.cs_n = CS_N_IDLE;
    // one select active within an access only
    if (next_st.phase != ST_IDLE && next_st.phase != ST_ADDR)
      next_st.pins.cs_n[next_st.cs] = 1'b0;
    next_st.pins.addr      = next_st.addr;
    next_st.pins.addr_oe_n = (next_st.phase == ST_IDLE);
    // multiplexed: address on data lines in address phase
    if (cs_cfg_i[next_st.cs].muxed && next_st.phase == ST_ADDR) begin
      next_st.pins.data      = next_st.addr[DATA_W-1:0];
      next_st.pins.data_oe_n = 1'b0;
    end else begin
      next_st.pins.data = (cs_cfg_i[next_st.cs].kind == CYC_HPI8 && next_st.cs >= 3'(HPI_CS_LO))
                        ? (next_st.half ? {8'h00, next_st.wdata[7:0]}
                                        : {8'h00, next_st.wdata[15:8]})
                        : next_st.wdata;
      next_st.pins.data_oe_n = !(next_st.write && next_st.phase inside {ST_SETUP, ST_STROBE,
                                                                       ST_HOLD});
    end
    next_st.pins.ale = (next_st.phase == ST_ADDR);
    next_st.busy     = (next_st.phase != ST_IDLE);
    if (cs_cfg_i[next_st.cs].style == STYLE_RDWR) begin
      next_st.pins.rd_n = !(strb && !next_st.write);
      next_st.pins.wr_n = !(strb && next_st.write);
    end else begin
      next_st.pins.rd_n = !(next_st.phase != ST_IDLE && !next_st.write);
      next_st.pins.wr_n = !strb;
    end
    if (!rstn_i) begin
      next_st          = '0;
      next_st.phase    = ST_IDLE;
      next_st.pins.cs_n      = CS_N_IDLE;
      next_st.pins.addr_oe_n = 1'b1;
      next_st.pins.data_oe_n = 1'b1;
      next_st.pins.rd_n      = 1'b1;
      next_st.pins.wr_n      = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    st <= next_st;
  end

  assign rsp_o   = st.rsp;
  assign busy_o  = st.busy;
  assign strap_o = st.strap;
  assign pins_o  = st.pins;
endmodule : exp_bus_ctrl
`default_nettype wire

//--- sim/exp_bus_ctrl_props.sv
// checker: port-level properties of the expansion bus controller
`timescale 1ns/1ps
`default_nettype none
module exp_bus_ctrl_props
  import exp_bus_pkg::*;
(
  // clock and reset
  input wire logic                             clk_sys_i,
  input wire logic                             rstn_i,
  // watched ports
  input wire exp_bus_pkg::req_t                req_i,
  input wire exp_bus_pkg::rsp_t                rsp_o,
  input wire logic                             busy_o,
  input wire logic [exp_bus_pkg::ADDR_W-1:0]   strap_o,
  input wire exp_bus_pkg::pins_t               pins_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_one_cs; $countones(~pins_o.cs_n) <= 1; endproperty
  a_one_cs: assert property (p_one_cs) else $error("two selects low");
  property p_idle; !busy_o |-> pins_o.cs_n == CS_N_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("select low while idle");
  property p_pulse; rsp_o.done |=> !rsp_o.done && !busy_o; endproperty
  a_pulse: assert property (p_pulse) else $error("done not a pulse");
  property p_ale; pins_o.ale |-> pins_o.cs_n == CS_N_IDLE; endproperty
  a_ale: assert property (p_ale) else $error("select during address");
  property p_wr_cs; !pins_o.wr_n |-> pins_o.cs_n != CS_N_IDLE; endproperty
  a_wr_cs: assert property (p_wr_cs) else $error("strobe outside select");
  property p_wr_drv; !pins_o.wr_n && req_i.write |-> !pins_o.data_oe_n; endproperty
  a_wr_drv: assert property (p_wr_drv) else $error("write data not driven");
  property p_bound; $rose(busy_o) |-> ##[1:200] rsp_o.done; endproperty
  a_bound: assert property (p_bound) else $error("access never ends");
  property p_strap; busy_o |-> $stable(strap_o); endproperty
  a_strap: assert property (p_strap) else $error("straps moved");
  property p_miss; rsp_o.miss |-> rsp_o.done; endproperty
  a_miss: assert property (p_miss) else $error("miss without done");
  property p_rst;
    disable iff (1'b0) !rstn_i |=> pins_o.cs_n == CS_N_IDLE && !busy_o;
  endproperty
  a_rst: assert property (p_rst) else $error("select or busy in reset");
  property p_addr;
    $rose(busy_o) |-> pins_o.ale && !pins_o.addr_oe_n && pins_o.addr == $past(req_i.addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address not driven at start");
endmodule : exp_bus_ctrl_props
bind exp_bus_ctrl exp_bus_ctrl_props i_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
  .req_i(req_i), .rsp_o(rsp_o), .busy_o(busy_o), .strap_o(strap_o), .pins_o(pins_o));
`default_nettype wire

//--- sim/exp_periph_model.sv
// peripheral model: strap pulls, read data source and write log
`timescale 1ns/1ps
`default_nettype none
module exp_periph_model
  import exp_bus_pkg::*;
(
  input  wire logic                           clk_sys_i,
  input  wire exp_bus_pkg::pins_t             pins_i,
  input  wire logic                           byte_i,
  input  wire logic [exp_bus_pkg::ADDR_W-1:0] strap_i,
  input  wire logic [exp_bus_pkg::DATA_W-1:0] rd_i,
  output logic [exp_bus_pkg::ADDR_W-1:0]      addr_o,
  output logic [exp_bus_pkg::DATA_W-1:0]      data_o,
  output logic [exp_bus_pkg::DATA_W-1:0]      wr_o
);
  logic [DATA_W-1:0] last = '0;
  logic [DATA_W-1:0] cur  = '0;
  logic [DATA_W-1:0] drv;
  logic              prd  = 1'b1;
  logic              pwr  = 1'b1;
  logic              hi   = 1'b1;
  logic              sel;
  assign sel = pins_i.cs_n != CS_N_IDLE;
  assign addr_o = pins_i.addr_oe_n ? strap_i : pins_i.addr;
  assign drv = byte_i ? {8'h00, hi ? rd_i[15:8] : rd_i[7:0]} : rd_i;
  // released lines toggle while no select is low, never hold
  assign data_o = !pins_i.data_oe_n ? pins_i.data : (sel ? drv : ~last);
  always @(posedge clk_sys_i) begin
    last <= data_o;
    prd  <= pins_i.rd_n;
    pwr  <= pins_i.wr_n;
    // each read strobe moves to the other byte
    if (!byte_i) hi <= 1'b1;
    else if (!prd && pins_i.rd_n) hi <= ~hi;
    if (!pins_i.wr_n && !pins_i.data_oe_n) cur <= pins_i.data;
    if (!pwr && pins_i.wr_n) wr_o <= byte_i ? {wr_o[7:0], cur[7:0]} : cur;
  end
endmodule : exp_periph_model
`default_nettype wire

//--- sim/tb.sv
// testbench: table of accesses through the expansion bus controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import exp_bus_pkg::*;
  localparam logic [23:0] STRAP = 24'h5a3c96;
  localparam logic [15:0] RDV   = 16'hc3a5;
  localparam logic [23:0] AD [8] = '{24'h0001fe, 24'h0001fe, 24'h010ffe, 24'h010ffe,
                                     24'h100010, 24'h200020, 24'h200020, 24'h000200};
  localparam logic [7:0]  WR    = 8'h25;
  logic              clk_sys_i = 1'b0;
  logic              rstn_i    = 1'b0;
  logic              busy;
  logic              bmode     = 1'b0;
  cs_cfg_t           cfg [NUM_CS];
  req_t              req       = '0;
  rsp_t              rsp;
  rsp_t              r;
  pins_t             pins;
  logic [ADDR_W-1:0] strap;
  logic [ADDR_W-1:0] apin;
  logic [DATA_W-1:0] dpin;
  logic [DATA_W-1:0] wlog;
  int                n;
  int                err_count = 0;
  int                tests_run = 0;
  exp_bus_ctrl i_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cs_cfg_i(cfg), .req_i(req),
    .rsp_o(rsp), .busy_o(busy), .strap_o(strap), .addr_pin_i(apin), .data_pin_i(dpin),
    .pins_o(pins));
  exp_periph_model i_mod (.clk_sys_i(clk_sys_i), .pins_i(pins), .byte_i(bmode),
    .strap_i(STRAP), .rd_i(RDV), .addr_o(apin), .data_o(dpin), .wr_o(wlog));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  function automatic cs_cfg_t mk(logic [23:0] b, logic [4:0] w, logic s, logic m,
                                 cyc_kind_t k);
    mk = '{1'b1, s, m, k, w, b, 4'h0, 4'h1, 4'h3, 4'h1, 4'h0};
  endfunction : mk
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(logic w, logic [23:0] a, logic [15:0] d);
    req = '{1'b1, w, a, d};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (rsp.done !== 1'b1 && n < 400);
    chk("done", 24'h000001, {23'h000000, rsp.done});
    r = rsp;
    req.valid = 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask : acc
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial begin
    foreach (cfg[k]) cfg[k] = '0;
    cfg[0] = mk(24'h000000, 5'h09, STYLE_RDWR, 1'b0, CYC_PLAIN);
    cfg[1] = mk(24'h010000, 5'h0c, STYLE_RWSTB, 1'b1, CYC_PLAIN);
    cfg[4] = mk(24'h100000, 5'h09, STYLE_RDWR, 1'b0, CYC_HPI16);
    cfg[5] = mk(24'h200000, 5'h09, STYLE_RDWR, 1'b1, CYC_HPI8);
    repeat (5) @(posedge clk_sys_i);
    #1;
    chk("cs_reset", {16'h0000, CS_N_IDLE}, {16'h0000, pins.cs_n});
    rstn_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    chk("strap", STRAP, strap);
    for (int i = 0; i < 8; i++) begin
      bmode = (i == 5 || i == 6);
      acc(WR[i], AD[i], 16'h9e10 ^ 16'(i));
      chk("miss", {23'h000000, i == 7}, {23'h000000, r.miss});
      if (i < 4) chk("latency", 24'h00000b, 24'(n));
      if (i == 7) chk("miss_latency", 24'h000001, 24'(n));
      if (WR[i]) chk("write", {8'h00, 16'h9e10 ^ 16'(i)}, {8'h00, wlog});
      else if (i < 7) chk("read", {8'h00, RDV}, {8'h00, r.rdata});
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
